// [test_tlic_controller.sv]
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "tlic_regs.svh"
module test_tlic_controller;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        pa = 1'b1, pb = 1'b1, ret_go = 1'b0;
    logic [3:0]  adr = 4'h0, slow = 4'h0, sel = 4'hf;
    logic [7:0]  ev = 8'h00, dat = 8'h00, vec, got_vec, n_got, n_exp = 8'h00;
    logic        vack, reti, int_req, irq, ack;
    logic [31:0] rdat, q;
    int          n_fail = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    tlic_controller u_tlic_controller (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({24'h0, dat}),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_source_a_i(pa), .ext_source_b_i(pb),
        .timer0_overflow_i(ev[1]), .timer1_overflow_i(ev[3]), .timer2_overflow_i(ev[6]),
        .timer2_external_i(ev[7]), .rx_done_i(ev[4]), .tx_done_i(ev[5]),
        .vector_ack_i(vack), .reti_i(reti), .int_req_o(int_req), .int_vector_o(vec),
        .irq_o(irq));
    tlic_core_model u_tlic_core_model (.clk_i, .rst_i, .int_req_i(int_req),
        .int_vector_i(vec), .slow_i(slow), .ret_go_i(ret_go), .vector_ack_o(vack),
        .reti_o(reti), .got_vec_o(got_vec), .n_got_o(n_got));
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task wb(input logic [3:0] a, input logic w, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1; we <= w; adr <= a; dat <= d;
        i = 0;
        do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin n_fail++; final_report; end
        q = rdat;
        cyc <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        wb(a, 1'b0, 8'h00);
        chk(nm, {24'h0, e}, q);
    endtask
    task pulse(input logic [7:0] m);
        @(posedge clk_i); ev <= m;
        @(posedge clk_i); ev <= 8'h00;
    endtask
    task ret;
        @(posedge clk_i); ret_go <= 1'b1;
        @(posedge clk_i); ret_go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Counting by total so a grant during a bus cycle is not missed
    task take(input logic [7:0] e);
        int i;
        n_exp = n_exp + 8'h01;
        for (i = 0; i < 60 && n_got !== n_exp; i++) @(posedge clk_i);
        if (n_got !== n_exp) begin n_fail++; final_report; end
        chk("vector", {24'h0, e}, {24'h0, got_vec});
        repeat (4) @(posedge clk_i);
        chk("held request", 32'h0, {31'h0, int_req});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(`TLIC_ADDR_ENABLE, `TLIC_ENABLE_RST, "enable");
        rd(`TLIC_ADDR_LEVEL, `TLIC_LEVEL_RST, "level");
        rd(`TLIC_ADDR_IRQ_MASK, {5'h0, `TLIC_IRQ_MASK_RST}, "mask");
        wb(4'hf, 1'b1, 8'hff);
        rd(4'hf, 8'h00, "unmapped");
        wb(`TLIC_ADDR_ENABLE, 1'b1, 8'hff);
        rd(`TLIC_ADDR_ENABLE, 8'hbf, "enable");
        sel <= 4'he;
        wb(`TLIC_ADDR_ENABLE, 1'b1, 8'h00);
        sel <= 4'hf;
        rd(`TLIC_ADDR_ENABLE, 8'hbf, "enable");
        wb(`TLIC_ADDR_LEVEL, 1'b1, 8'hff);
        rd(`TLIC_ADDR_LEVEL, 8'h3f, "level");
        $display("test regs done");
    endtask
    task t_poll;
        wb(`TLIC_ADDR_ENABLE, 1'b1, 8'h3f);
        wb(`TLIC_ADDR_LEVEL, 1'b1, 8'h00);
        wb(`TLIC_ADDR_CTRL, 1'b1, 8'h01);
        pa <= 1'b0; pb <= 1'b0;
        pulse(8'hfa);
        repeat (4) @(posedge clk_i);
        pa <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("masked request", 32'h0, {31'h0, int_req});
        rd(`TLIC_ADDR_FLAGS, 8'hff, "flags");
        wb(`TLIC_ADDR_ENABLE, 1'b1, 8'hbf);
        take(8'h03);
        ret;
        take(8'h0b);
        ret;
        take(8'h13);
        rd(`TLIC_ADDR_FLAGS, 8'hfc, "flags");
        pb <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(`TLIC_ADDR_FLAGS, 1'b1, 8'hf8);
        ret;
        take(8'h1b);
        rd(`TLIC_ADDR_FLAGS, 8'hf0, "flags");
        ret;
        take(8'h23);
        rd(`TLIC_ADDR_FLAGS, 8'hf0, "flags");
        wb(`TLIC_ADDR_FLAGS, 1'b1, 8'hc0);
        ret;
        take(8'h2b);
        rd(`TLIC_ADDR_FLAGS, 8'hc0, "flags");
        wb(`TLIC_ADDR_FLAGS, 1'b1, 8'h00);
        ret;
        $display("test polling done");
    endtask
    task t_nest;
        slow <= 4'h3;
        wb(`TLIC_ADDR_LEVEL, 1'b1, 8'h02);
        pulse(8'h08);
        take(8'h1b);
        pulse(8'h40);
        repeat (4) @(posedge clk_i);
        chk("held request", 32'h0, {31'h0, int_req});
        pulse(8'h02);
        take(8'h0b);
        rd(`TLIC_ADDR_SERVICE, 8'h14, "service");
        ret;
        rd(`TLIC_ADDR_SERVICE, 8'h02, "service");
        chk("held request", 32'h0, {31'h0, int_req});
        ret;
        take(8'h2b);
        wb(`TLIC_ADDR_FLAGS, 1'b1, 8'h00);
        ret;
        $display("test nesting done");
    endtask
    task t_irq;
        rd(`TLIC_ADDR_IRQ_STATUS, 8'h07, "events");
        wb(`TLIC_ADDR_IRQ_MASK, 1'b1, 8'h01);
        pulse(8'h08);
        take(8'h1b);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`TLIC_ADDR_IRQ_STATUS, 8'h01, "events");
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        wb(`TLIC_ADDR_IRQ_MASK, 1'b1, 8'h00);
        ret;
        chk("irq", 32'h0, {31'h0, irq});
        rd(`TLIC_ADDR_IRQ_STATUS, 8'h04, "events");
        $display("test events done");
    endtask
    // Opposite pin modes: ext1 edge, ext0 level
    task t_modes;
        wb(`TLIC_ADDR_CTRL, 1'b1, 8'h02);
        wb(`TLIC_ADDR_LEVEL, 1'b1, 8'h00);
        pb <= 1'b0;
        take(8'h13);
        rd(`TLIC_ADDR_FLAGS, 8'h00, "flags");
        ret;
        pb <= 1'b1;
        pa <= 1'b0;
        take(8'h03);
        rd(`TLIC_ADDR_FLAGS, 8'h01, "flags");
        pa <= 1'b1;
        repeat (4) @(posedge clk_i);
        wb(`TLIC_ADDR_FLAGS, 1'b1, 8'h00);
        ret;
        $display("test modes done");
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_poll;
        t_nest;
        t_irq;
        t_modes;
        final_report;
    end
endmodule
bind tlic_controller tlic_controller_assertions u_tlic_controller_assertions (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vector_ack_i(vector_ack_i),
    .int_req_o(int_req_o), .int_vector_o(int_vector_o), .irq_o(irq_o));
`default_nettype wire

// [tlic_controller.sv]
// Two-level six-source interrupt controller with a classic Wishbone register port
//
// Overview of operation
// - Six sources, each at one of two levels.
// - Priority bit 0 low level, 1 high.
// - Grant when nothing same-or-higher is in service.
// - Hold request while equal-or-higher level serviced.
// - High request preempts active low handler immediately.
// - Resume suspended low handler; depth at most two.
// - Same level ordered ext0,tmr0,ext1,tmr1,serial,tmr2.
// - Edge-mode external flag cleared on vectoring; level not.
// - Timer 0/1 overflow flags cleared on vectoring.
// - Timer 2 request is overflow OR external; software clears.
// - Enable reg: global bit 7, sources bits 5..0.
// - Level reg: sources bits 5..0, 7..6 reserved.
//
// Our own choices: register access over Wishbone and the register addresses.
`include "tlic_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tlic_controller #(
    parameter int NSRC = 6
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:2]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_source_a_i,
    input  wire logic        ext_source_b_i,
    input  wire logic        timer0_overflow_i,
    input  wire logic        timer1_overflow_i,
    input  wire logic        timer2_overflow_i,
    input  wire logic        timer2_external_i,
    input  wire logic        rx_done_i,
    input  wire logic        tx_done_i,
    input  wire logic        vector_ack_i,
    input  wire logic        reti_i,
    output logic             int_req_o,
    output logic      [7:0]  int_vector_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection for the external inputs

    logic [1:0] ext_meta_ff;
    logic [1:0] ext_sync_ff;
    logic [1:0] ext_prev_ff;

    always_ff @(posedge clk_i) begin
        // Reset to the idle pin level, so no false request or edge follows reset
        if (rst_i) begin
            ext_meta_ff <= 2'h3;
            ext_sync_ff <= 2'h3;
            ext_prev_ff <= 2'h3;
        end else begin
            ext_meta_ff <= {ext_source_b_i, ext_source_a_i};
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] irq_enable_mask_ff;
    logic [7:0] irq_level_select_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] flags_ff;
    logic [2:0] evt_status_ff;
    logic [2:0] evt_mask_ff;
    logic       ack_ff;
    logic [31:0] rdat_ff;

    wire        bus_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    wire        bus_wr     = bus_req && wb_we_i && wb_sel_i[0];
    wire        bus_rd     = bus_req && !wb_we_i;
    wire        wr_enable  = bus_wr && (wb_adr_i == `TLIC_ADDR_ENABLE);
    wire        wr_level   = bus_wr && (wb_adr_i == `TLIC_ADDR_LEVEL);
    wire        wr_flags   = bus_wr && (wb_adr_i == `TLIC_ADDR_FLAGS);
    wire        wr_ctrl    = bus_wr && (wb_adr_i == `TLIC_ADDR_CTRL);
    wire        wr_mask    = bus_wr && (wb_adr_i == `TLIC_ADDR_IRQ_MASK);
    wire        rd_status  = bus_rd && (wb_adr_i == `TLIC_ADDR_IRQ_STATUS);

    wire        global_irq_enable = irq_enable_mask_ff[`TLIC_EN_GLOBAL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Request flags

    wire ext0_edge_mode = ctrl_ff[`TLIC_CTRL_IT0_BIT];
    wire ext1_edge_mode = ctrl_ff[`TLIC_CTRL_IT1_BIT];
    // Inputs are active low, as on a classic port pin
    wire ext0_fall = ext_prev_ff[0] && !ext_sync_ff[0];
    wire ext1_fall = ext_prev_ff[1] && !ext_sync_ff[1];
    wire ext0_set  = ext0_edge_mode ? ext0_fall : !ext_sync_ff[0];
    wire ext1_set  = ext1_edge_mode ? ext1_fall : !ext_sync_ff[1];

    wire [7:0] hw_set = {timer2_external_i, timer2_overflow_i, tx_done_i, rx_done_i,
                         timer1_overflow_i, ext1_set, timer0_overflow_i, ext0_set};

    // Per-source request lines in polling order
    wire [NSRC-1:0] src_req = {
        flags_ff[`TLIC_FLAG_T2OV_BIT] | flags_ff[`TLIC_FLAG_T2EX_BIT],
        flags_ff[`TLIC_FLAG_RX_BIT] | flags_ff[`TLIC_FLAG_TX_BIT],
        flags_ff[`TLIC_FLAG_TMR1_BIT],
        flags_ff[`TLIC_FLAG_EXT1_BIT],
        flags_ff[`TLIC_FLAG_TMR0_BIT],
        flags_ff[`TLIC_FLAG_EXT0_BIT]};

    wire [NSRC-1:0] armed = src_req & irq_enable_mask_ff[NSRC-1:0]
                            & {NSRC{global_irq_enable}};
    wire [NSRC-1:0] lvl   = irq_level_select_ff[NSRC-1:0];
    wire [NSRC-1:0] hi_req = armed & lvl;
    wire [NSRC-1:0] lo_req = armed & ~lvl;

    ////////////////////////////////////////////////////////////////////////
    // Arbitration

    // Lowest index wins: that is the fixed polling order
    function automatic logic [2:0] tlic_pick(input logic [NSRC-1:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [7:0] tlic_vector(input logic [2:0] idx);
        logic [7:0] v;
        case (idx)
            3'h0:    v = `TLIC_VEC_EXT0;
            3'h1:    v = `TLIC_VEC_TMR0;
            3'h2:    v = `TLIC_VEC_EXT1;
            3'h3:    v = `TLIC_VEC_TMR1;
            3'h4:    v = `TLIC_VEC_SER;
            default: v = `TLIC_VEC_TMR2;
        endcase
        return v;
    endfunction

    tlic_pkg::tlic_state_t state_ff;
    tlic_pkg::tlic_state_t nxt_state;
    logic       req_pending_ff;
    logic [2:0] req_idx_ff;
    logic       req_hi_ff;

    wire        in_high  = (state_ff == tlic_pkg::TLIC_HIGH);
    wire        in_low   = (state_ff == tlic_pkg::TLIC_LOW);
    wire        any_hi   = |hi_req;
    wire        any_lo   = |lo_req;
    wire        can_hi   = any_hi && !in_high;
    wire        can_lo   = any_lo && (state_ff == tlic_pkg::TLIC_IDLE);
    wire [2:0]  win_idx  = any_hi ? tlic_pick(hi_req) : tlic_pick(lo_req);
    wire        win_ok   = can_hi || can_lo;
    wire        take     = req_pending_ff && vector_ack_i;
    // Request withdrawn if the flag vanished or a higher source appeared
    wire        stale    = req_pending_ff && (!win_ok || win_idx != req_idx_ff ||
                                              any_hi != req_hi_ff);
    wire        suspended_ff_w;
    logic       low_suspended_ff;

    // Hardware clears edge-mode external and timer 0/1 flags on vectoring
    wire [7:0] vec_clr = !take ? 8'h00 :
        (req_idx_ff == 3'h0 && ext0_edge_mode) ? 8'h01 :
        (req_idx_ff == 3'h1)                   ? 8'h02 :
        (req_idx_ff == 3'h2 && ext1_edge_mode) ? 8'h04 :
        (req_idx_ff == 3'h3)                   ? 8'h08 : 8'h00;

    // Set wins over both software and vectoring clears
    wire [7:0] nxt_flags = hw_set | (flags_ff & ~vec_clr &
                                     ~(wr_flags ? ~wb_dat_i[7:0] : 8'h00));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tlic_pkg::TLIC_IDLE: begin
                if (take) begin
                    nxt_state = req_hi_ff ? tlic_pkg::TLIC_HIGH : tlic_pkg::TLIC_LOW;
                end
            end
            tlic_pkg::TLIC_LOW: begin
                if (take && req_hi_ff) begin
                    nxt_state = tlic_pkg::TLIC_HIGH;
                end else if (reti_i) begin
                    nxt_state = tlic_pkg::TLIC_IDLE;
                end
            end
            tlic_pkg::TLIC_HIGH: begin
                if (reti_i) begin
                    nxt_state = low_suspended_ff ? tlic_pkg::TLIC_LOW
                                                 : tlic_pkg::TLIC_IDLE;
                end
            end
            default: nxt_state = tlic_pkg::TLIC_IDLE;
        endcase
    end

    assign suspended_ff_w = low_suspended_ff;

    wire [2:0] evt_now = {reti_i && !in_high && !in_low ? 1'b0 : reti_i,
                          take && in_low && req_hi_ff,
                          take};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff         <= tlic_pkg::TLIC_IDLE;
            low_suspended_ff <= 1'b0;
            req_pending_ff   <= 1'b0;
            req_idx_ff       <= 3'h0;
            req_hi_ff        <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (take && in_low && req_hi_ff) begin
                low_suspended_ff <= 1'b1;
            end else if (reti_i && in_high) begin
                low_suspended_ff <= 1'b0;
            end
            if (take || stale || reti_i) begin
                req_pending_ff <= 1'b0;
            end else if (!req_pending_ff && win_ok) begin
                req_pending_ff <= 1'b1;
                req_idx_ff     <= win_idx;
                req_hi_ff      <= any_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and bus answer

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_mask_ff  <= `TLIC_ENABLE_RST;
            irq_level_select_ff <= `TLIC_LEVEL_RST;
            ctrl_ff             <= `TLIC_CTRL_RST;
            flags_ff            <= 8'h00;
            evt_mask_ff         <= `TLIC_IRQ_MASK_RST;
        end else begin
            if (wr_enable) begin
                irq_enable_mask_ff <= wb_dat_i[7:0] & `TLIC_ENABLE_WMASK;
            end
            if (wr_level) begin
                irq_level_select_ff <= wb_dat_i[7:0] & `TLIC_LEVEL_WMASK;
            end
            if (wr_ctrl) begin
                ctrl_ff <= wb_dat_i[7:0] & 8'h03;
            end
            if (wr_mask) begin
                evt_mask_ff <= wb_dat_i[2:0];
            end
            flags_ff <= nxt_flags;
        end
    end

    // Read clears status, but an event in the same cycle survives
    wire [2:0] nxt_evt = evt_now | (rd_status ? 3'h0 : evt_status_ff);

    wire [31:0] rd_mux =
        (wb_adr_i == `TLIC_ADDR_ENABLE)     ? {24'h0, irq_enable_mask_ff} :
        (wb_adr_i == `TLIC_ADDR_LEVEL)      ? {24'h0, irq_level_select_ff} :
        (wb_adr_i == `TLIC_ADDR_FLAGS)      ? {24'h0, flags_ff} :
        (wb_adr_i == `TLIC_ADDR_CTRL)       ? {24'h0, ctrl_ff} :
        (wb_adr_i == `TLIC_ADDR_SERVICE)    ? {27'h0, suspended_ff_w, 1'b0, state_ff} :
        (wb_adr_i == `TLIC_ADDR_IRQ_STATUS) ? {29'h0, evt_status_ff} :
        (wb_adr_i == `TLIC_ADDR_IRQ_MASK)   ? {29'h0, evt_mask_ff} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff        <= 1'b0;
            rdat_ff       <= 32'h0;
            evt_status_ff <= 3'h0;
            irq_o         <= 1'b0;
        end else begin
            ack_ff        <= bus_req;
            rdat_ff       <= bus_rd ? rd_mux : 32'h0;
            evt_status_ff <= nxt_evt;
            irq_o         <= |(nxt_evt & evt_mask_ff);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Core request outputs

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_req_o    <= 1'b0;
            int_vector_o <= 8'h00;
        end else begin
            int_req_o    <= req_pending_ff && !take && !stale && !reti_i;
            int_vector_o <= tlic_vector(req_idx_ff);
        end
    end

endmodule

`default_nettype wire

// [tlic_controller_assertions.sv]
// Port-level concurrent checks of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tlic_controller_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        vector_ack_i,
    input wire logic        int_req_o,
    input wire logic [7:0]  int_vector_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_data_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_vector_legal: assert property (
        int_req_o |-> int_vector_o inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b})
        else $error("offered vector not a source vector");
    a_grant_drops_req: assert property (int_req_o && vector_ack_i |=> !int_req_o)
        else $error("request stands after vector taken");
    a_reset_quiet: assert property ($fell(rst_i) |-> !int_req_o && !irq_o && !wb_ack_o)
        else $error("output active right after reset");
endmodule
`default_nettype wire

// [tlic_core_model.sv]
// Behavioural processor core: takes offered vectors and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       int_req_i,
    input  wire logic [7:0] int_vector_i,
    input  wire logic [3:0] slow_i,
    input  wire logic       ret_go_i,
    output logic            vector_ack_o,
    output logic            reti_o,
    output logic      [7:0] got_vec_o,
    output logic      [7:0] n_got_o
);
    logic [3:0] wait_ff;
    // Ack only after the request stood slow_i cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vector_ack_o <= 1'b0;
            reti_o       <= 1'b0;
            wait_ff      <= 4'h0;
            got_vec_o    <= 8'h00;
            n_got_o      <= 8'h00;
        end else begin
            reti_o       <= ret_go_i;
            vector_ack_o <= 1'b0;
            if (vector_ack_o) begin
                got_vec_o <= int_vector_i;
                n_got_o   <= n_got_o + 8'h01;
                wait_ff   <= 4'h0;
            end else if (!int_req_i) begin
                wait_ff <= 4'h0;
            end else if (wait_ff >= slow_i) begin
                vector_ack_o <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [tlic_pkg.sv]
// Types shared by the interrupt controller
package tlic_pkg;
    typedef enum logic [2:0] {
        TLIC_IDLE = 3'b001,
        TLIC_LOW  = 3'b010,
        TLIC_HIGH = 3'b100
    } tlic_state_t;
endpackage

// [tlic_regs.svh]
// Register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef TLIC_REGS_SVH
`define TLIC_REGS_SVH

`define TLIC_ADDR_ENABLE      4'h0
`define TLIC_ADDR_LEVEL       4'h1
`define TLIC_ADDR_FLAGS       4'h2
`define TLIC_ADDR_CTRL        4'h3
`define TLIC_ADDR_SERVICE     4'h4
`define TLIC_ADDR_IRQ_STATUS  4'h5
`define TLIC_ADDR_IRQ_MASK    4'h6

`define TLIC_EN_GLOBAL_BIT    7
`define TLIC_ENABLE_RST       8'h00
`define TLIC_LEVEL_RST        8'h00
`define TLIC_ENABLE_WMASK     8'hbf
`define TLIC_LEVEL_WMASK      8'h3f

`define TLIC_CTRL_IT0_BIT     0
`define TLIC_CTRL_IT1_BIT     1
`define TLIC_CTRL_RST         8'h00

`define TLIC_FLAG_EXT0_BIT    0
`define TLIC_FLAG_TMR0_BIT    1
`define TLIC_FLAG_EXT1_BIT    2
`define TLIC_FLAG_TMR1_BIT    3
`define TLIC_FLAG_RX_BIT      4
`define TLIC_FLAG_TX_BIT      5
`define TLIC_FLAG_T2OV_BIT    6
`define TLIC_FLAG_T2EX_BIT    7

`define TLIC_VEC_EXT0         8'h03
`define TLIC_VEC_TMR0         8'h0b
`define TLIC_VEC_EXT1         8'h13
`define TLIC_VEC_TMR1         8'h1b
`define TLIC_VEC_SER          8'h23
`define TLIC_VEC_TMR2         8'h2b

`define TLIC_EVT_GRANT_BIT    0
`define TLIC_EVT_PREEMPT_BIT  1
`define TLIC_EVT_RETI_BIT     2
`define TLIC_IRQ_MASK_RST     3'h0

`endif
